// >>> verilog/rad_uart.sv
`default_nettype none
// Function
// - In two-wire mode the driver turns on as soon as transmit data waits.
// - Driver stays on one more character time after the last one, then releases.
// - The hold interval is counted in ticks of the programmed bit rate.
// - Receiver is off while the driver is on in two-wire mode.
// - Transmit and receive each buffer sixteen bytes in a first-in first-out store.
// - Rates reach 115,200 from the oscillator, 460,800 with the four-times clock jumper.
// - In two-wire mode all nodes share one pair, one direction at a time.
// - Four-wire mode sends and receives together with no driver turnaround.
module rad_uart (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire rad_pkg::rad_cfg_s cfg_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    output rad_pkg::rad_rx_word_s rx_word_o,
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    output logic rx_overrun_o,
    input wire logic line_rxd_i,
    output logic line_txd_o,
    output logic line_drv_en_o,
    output logic line_rx_en_o
);
    import rad_pkg::*;

    rad_state_s q;
    rad_state_s d;
    logic tick;
    logic tx_push;

    function automatic logic fifo_empty(input logic [FIFO_AW:0] wp, input logic [FIFO_AW:0] rp);
        return wp == rp;
    endfunction : fifo_empty

    function automatic logic fifo_full(input logic [FIFO_AW:0] wp, input logic [FIFO_AW:0] rp);
        return (wp[FIFO_AW] != rp[FIFO_AW]) && (wp[FIFO_AW-1:0] == rp[FIFO_AW-1:0]);
    endfunction : fifo_full

    function automatic logic [7:0] stop_ticks(input logic [1:0] sel);
        if (sel == STOP_SEL_1)
        begin
            return STOP_TICKS_1;
        end
        if (sel == STOP_SEL_15)
        begin
            return STOP_TICKS_15;
        end
        return STOP_TICKS_2;
    endfunction : stop_ticks

    function automatic logic [7:0] char_ticks(input rad_cfg_s c);
        logic [3:0] bits;
        bits = START_BITS + WORD_LEN_BASE + {2'h0, c.word_len} + {3'h0, c.parity_en};
        return {bits, 4'h0} + stop_ticks(c.stop_sel);
    endfunction : char_ticks

    assign tx_ready_o = ce_i && !fifo_full(q.tx_wp, q.tx_rp);
    assign tx_push = tx_valid_i && tx_ready_o;
    assign rx_word_o = q.rx_out;
    assign rx_valid_o = q.rx_out_v;
    assign rx_overrun_o = q.overrun;
    assign line_txd_o = q.txd;
    assign line_drv_en_o = q.de;
    assign line_rx_en_o = q.re;

    always_comb
    begin
        d = q;
        tick = 1'b0;
        if (ce_i)
        begin
            // Oversample tick: prescale by jumper, then by the programmed divisor.
            d.pre = q.pre + 2'h1;
            if (q.pre >= (cfg_i.clk_x4 ? PRE_LAST_X4 : PRE_LAST_X1))
            begin
                d.pre = 2'h0;
                d.div = q.div + 16'h0001;
                if (cfg_i.divisor == 16'h0000 || q.div >= cfg_i.divisor - DIV_ONE)
                begin
                    d.div = 16'h0000;
                    tick = 1'b1;
                end
            end
            if (tx_push)
            begin
                d.tx_mem[q.tx_wp[FIFO_AW-1:0]] = tx_data_i;
                d.tx_wp = q.tx_wp + 5'h01;
            end
            if (tick)
            begin
                case (q.tx_st)
                    TX_IDLE, TX_HOLD:
                    begin
                        if (!fifo_empty(q.tx_wp, q.tx_rp))
                        begin
                            d.tx_sh = q.tx_mem[q.tx_rp[FIFO_AW-1:0]];
                            d.tx_rp = q.tx_rp + 5'h01;
                            d.tx_st = TX_START;
                            d.tx_os = 4'h0;
                            d.txd = 1'b0;
                            d.tx_par = !cfg_i.parity_even;
                        end
                        else if (q.tx_st == TX_HOLD)
                        begin
                            d.hold_cnt = q.hold_cnt - 8'h01;
                            if (q.hold_cnt == 8'h00)
                            begin
                                d.tx_st = TX_IDLE;
                            end
                        end
                    end
                    TX_START:
                    begin
                        d.tx_os = q.tx_os + 4'h1;
                        if (q.tx_os == OS_LAST)
                        begin
                            d.tx_st = TX_DATA;
                            d.tx_bit = 3'h0;
                            d.txd = q.tx_sh[0];
                        end
                    end
                    TX_DATA:
                    begin
                        d.tx_os = q.tx_os + 4'h1;
                        if (q.tx_os == OS_LAST)
                        begin
                            d.tx_par = q.tx_par ^ q.tx_sh[0];
                            d.tx_sh = {1'b0, q.tx_sh[7:1]};
                            d.tx_bit = q.tx_bit + 3'h1;
                            d.txd = q.tx_sh[1];
                            if (q.tx_bit == LAST_BIT_BASE + {1'b0, cfg_i.word_len})
                            begin
                                d.tx_st = cfg_i.parity_en ? TX_PAR : TX_STOP;
                                d.txd = cfg_i.parity_en ? (q.tx_par ^ q.tx_sh[0]) : LINE_IDLE;
                                d.hold_cnt = stop_ticks(cfg_i.stop_sel) - 8'h01;
                            end
                        end
                    end
                    TX_PAR:
                    begin
                        d.tx_os = q.tx_os + 4'h1;
                        if (q.tx_os == OS_LAST)
                        begin
                            d.tx_st = TX_STOP;
                            d.txd = LINE_IDLE;
                        end
                    end
                    TX_STOP:
                    begin
                        d.hold_cnt = q.hold_cnt - 8'h01;
                        if (q.hold_cnt == 8'h00)
                        begin
                            // The shifter is empty here; two-wire mode starts the trailing hold, four-wire goes idle.
                            d.tx_st = cfg_i.mode_485 ? TX_HOLD : TX_IDLE;
                            d.hold_cnt = char_ticks(cfg_i) - 8'h01;
                        end
                    end
                    default: d.tx_st = TX_IDLE;
                endcase
            end
            // Four-wire keeps both ends on; two-wire drives only while busy.
            d.de = !cfg_i.mode_485 || !fifo_empty(d.tx_wp, d.tx_rp) || d.tx_st != TX_IDLE;
            d.re = !cfg_i.mode_485 || !d.de;
            d.rx_meta = line_rxd_i;
            d.rx_sync = q.rx_meta;
            d.overrun = 1'b0;
            if (q.rx_out_v && rx_ready_i)
            begin
                d.rx_out_v = 1'b0;
            end
            if (!d.rx_out_v && !fifo_empty(q.rx_wp, q.rx_rp))
            begin
                d.rx_out = q.rx_mem[q.rx_rp[FIFO_AW-1:0]];
                d.rx_out_v = 1'b1;
                d.rx_rp = q.rx_rp + 5'h01;
            end
            if (!q.re)
            begin
                d.rx_st = RX_IDLE;
            end
            else if (tick)
            begin
                d.rx_os = q.rx_os + 4'h1;
                case (q.rx_st)
                    RX_IDLE:
                    begin
                        d.rx_os = 4'h0;
                        if (!q.rx_sync)
                        begin
                            d.rx_st = RX_START;
                        end
                    end
                    RX_START:
                    begin
                        if (q.rx_os == OS_MID)
                        begin
                            d.rx_st = q.rx_sync ? RX_IDLE : RX_DATA;
                            d.rx_os = 4'h0;
                            d.rx_bit = 3'h0;
                            d.rx_par = !cfg_i.parity_even;
                            d.rx_pe = 1'b0;
                        end
                    end
                    RX_DATA:
                    begin
                        if (q.rx_os == OS_LAST)
                        begin
                            d.rx_sh = {q.rx_sync, q.rx_sh[7:1]};
                            d.rx_par = q.rx_par ^ q.rx_sync;
                            d.rx_bit = q.rx_bit + 3'h1;
                            if (q.rx_bit == LAST_BIT_BASE + {1'b0, cfg_i.word_len})
                            begin
                                d.rx_st = cfg_i.parity_en ? RX_PAR : RX_STOP;
                            end
                        end
                    end
                    RX_PAR:
                    begin
                        if (q.rx_os == OS_LAST)
                        begin
                            d.rx_pe = q.rx_par ^ q.rx_sync;
                            d.rx_st = RX_STOP;
                        end
                    end
                    RX_STOP:
                    begin
                        if (q.rx_os == OS_LAST)
                        begin
                            d.rx_st = RX_IDLE;
                            if (fifo_full(q.rx_wp, q.rx_rp))
                            begin
                                d.overrun = 1'b1;
                            end
                            else
                            begin
                                d.rx_mem[q.rx_wp[FIFO_AW-1:0]] = {!q.rx_sync, q.rx_pe,
                                    q.rx_sh >> (3'(WORD_LEN_MAX - cfg_i.word_len))};
                                d.rx_wp = q.rx_wp + 5'h01;
                            end
                        end
                    end
                    default: d.rx_st = RX_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            q <= '0;
            q.txd <= LINE_IDLE;
            q.rx_meta <= LINE_IDLE;
            q.rx_sync <= LINE_IDLE;
            q.re <= 1'b1;
        end
        else if (ce_i)
        begin
            q <= d;
        end
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    property p_drv_on_pending;
        ce_i && cfg_i.mode_485 && !fifo_empty(q.tx_wp, q.tx_rp) |=> line_drv_en_o;
    endproperty
    a_drv_on_pending: assert property (p_drv_on_pending) else $error("driver off with data waiting");

    property p_drv_during_frame;
        ce_i && cfg_i.mode_485 && q.tx_st != TX_IDLE |-> line_drv_en_o;
    endproperty
    a_drv_during_frame: assert property (p_drv_during_frame) else $error("driver off mid frame");

    property p_release_after_idle;
        $fell(line_drv_en_o) && $past(ce_i) && $past(cfg_i.mode_485)
            |-> q.tx_st == TX_IDLE && $past(q.tx_st) == TX_HOLD;
    endproperty
    a_release_after_idle: assert property (p_release_after_idle) else $error("early release");

    property p_hold_len;
        $past(ce_i) && $past(q.tx_st) == TX_STOP && q.tx_st == TX_HOLD
            |-> q.hold_cnt == char_ticks($past(cfg_i)) - 8'h01;
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("hold length wrong");

    property p_rx_off_driving;
        $past(ce_i) && $past(cfg_i.mode_485) |-> !(line_drv_en_o && line_rx_en_o);
    endproperty
    a_rx_off_driving: assert property (p_rx_off_driving) else $error("receiver on while driving");

    property p_fifo_bound;
        (q.tx_wp - q.tx_rp) <= 5'h10 && (q.rx_wp - q.rx_rp) <= 5'h10;
    endproperty
    a_fifo_bound: assert property (p_fifo_bound) else $error("fifo count beyond depth");

    property p_tick_spacing;
        tick && ce_i && !cfg_i.clk_x4 |=> (cfg_i.clk_x4 || !tick) ##1 (cfg_i.clk_x4 || !tick);
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("x1 tick too fast");

    property p_full_duplex;
        $past(ce_i) && !$past(cfg_i.mode_485) |-> line_drv_en_o && line_rx_en_o;
    endproperty
    a_full_duplex: assert property (p_full_duplex) else $error("four-wire turnaround");

    property p_mark_when_quiet;
        q.tx_st == TX_IDLE || q.tx_st == TX_HOLD || q.tx_st == TX_STOP |-> line_txd_o;
    endproperty
    a_mark_when_quiet: assert property (p_mark_when_quiet) else $error("line not at mark");

    c_release: cover property ($fell(line_drv_en_o));
    c_back_to_back: cover property (q.tx_st == TX_HOLD ##1 q.tx_st == TX_START);
    c_rx_word: cover property (rx_valid_o && rx_ready_i);
    c_overrun: cover property (rx_overrun_o);
endmodule : rad_uart
`default_nettype wire

// >>> verilog/rad_pkg.sv
`default_nettype none
package rad_pkg;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW = 4;
    // Oversample ticks per bit and the sample points inside one bit.
    localparam logic [3:0] OS_MID = 4'h7;
    localparam logic [3:0] OS_LAST = 4'hF;
    // Reference cycles per oversample tick step: x1 jumper divides by 4, x4 by 1.
    localparam logic [1:0] PRE_LAST_X1 = 2'h3;
    localparam logic [1:0] PRE_LAST_X4 = 2'h0;
    localparam logic [15:0] DIV_ONE = 16'h0001;
    localparam logic [3:0] START_BITS = 4'h1;
    localparam logic [3:0] WORD_LEN_BASE = 4'h5;
    localparam logic [1:0] WORD_LEN_MAX = 2'h3;
    localparam logic [2:0] LAST_BIT_BASE = 3'h4;
    localparam logic [7:0] STOP_TICKS_1 = 8'h10;
    localparam logic [7:0] STOP_TICKS_15 = 8'h18;
    localparam logic [7:0] STOP_TICKS_2 = 8'h20;
    localparam logic [1:0] STOP_SEL_1 = 2'h0;
    localparam logic [1:0] STOP_SEL_15 = 2'h1;
    // Values after reset.
    localparam logic LINE_IDLE = 1'b1;

    typedef struct packed {
        logic mode_485;
        logic clk_x4;
        logic [1:0] word_len;
        logic parity_en;
        logic parity_even;
        logic [1:0] stop_sel;
        logic [15:0] divisor;
    } rad_cfg_s;

    typedef struct packed {
        logic frame_err;
        logic parity_err;
        logic [7:0] data;
    } rad_rx_word_s;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_HOLD} rad_tx_e;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rad_rx_e;

    typedef struct packed {
        logic [1:0] pre;
        logic [15:0] div;
        rad_tx_e tx_st;
        logic [3:0] tx_os;
        logic [2:0] tx_bit;
        logic [7:0] tx_sh;
        logic tx_par;
        logic [7:0] hold_cnt;
        logic txd;
        logic de;
        logic re;
        logic [FIFO_DEPTH-1:0][7:0] tx_mem;
        logic [FIFO_AW:0] tx_wp;
        logic [FIFO_AW:0] tx_rp;
        logic rx_meta;
        logic rx_sync;
        rad_rx_e rx_st;
        logic [3:0] rx_os;
        logic [2:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_par;
        logic rx_pe;
        logic [FIFO_DEPTH-1:0][9:0] rx_mem;
        logic [FIFO_AW:0] rx_wp;
        logic [FIFO_AW:0] rx_rp;
        rad_rx_word_s rx_out;
        logic rx_out_v;
        logic overrun;
    } rad_state_s;
endpackage : rad_pkg
`default_nettype wire

// >>> test/rad_line_node.sv
`default_nettype none
module rad_line_node (
    input wire logic clk_i,
    input wire logic txd_i,
    input wire logic drv_en_i,
    input wire logic mode_485_i,
    output logic line_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Bias holds the released pair at the mark level.
    initial line_o = 1'b1;

    // Sends n bits LSB first, each bc cycles, then leaves the line idle.
    task automatic send(input logic [11:0] f, input int n, input int bc);
        while (mode_485_i && drv_en_i)
            @(negedge clk_i);
        for (int i = 0; i < n; i++)
        begin
            @(negedge clk_i);
            line_o = f[i];
            repeat (bc - 1) @(negedge clk_i);
        end
        @(negedge clk_i);
        line_o = 1'b1;
        repeat (2 * bc) @(negedge clk_i);
    endtask : send

    // Samples n bits from the falling start edge at the middle of each bit.
    task automatic recv(input int n, input int bc, output logic [11:0] f);
        f = '0;
        @(negedge clk_i);
        while (txd_i !== 1'b0)
            @(negedge clk_i);
        repeat (bc / 2) @(negedge clk_i);
        for (int i = 0; i < n; i++)
        begin
            f[i] = txd_i;
            if (i < n - 1)
                repeat (bc) @(negedge clk_i);
        end
    endtask : recv
endmodule : rad_line_node
`default_nettype wire

// >>> test/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rad_pkg::*;
    logic ref_clk_i, rst_i, ce_i, tx_valid_i, rx_ready_i, node_line, line_rxd_i;
    logic [7:0] tx_data_i;
    rad_cfg_s cfg_i;
    rad_rx_word_s rx_word_o;
    logic tx_ready_o, rx_valid_o, rx_overrun_o, line_txd_o, line_drv_en_o, line_rx_en_o;
    int n_errors = 0;
    int cmp_count = 0;

    // The shared pair carries our own driver while it is on in two-wire mode.
    assign line_rxd_i = (cfg_i.mode_485 && line_drv_en_o) ? line_txd_o : node_line;

    rad_uart DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i), .cfg_i(cfg_i),
        .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
        .rx_word_o(rx_word_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
        .rx_overrun_o(rx_overrun_o), .line_rxd_i(line_rxd_i), .line_txd_o(line_txd_o),
        .line_drv_en_o(line_drv_en_o), .line_rx_en_o(line_rx_en_o));
    rad_line_node node (.clk_i(ref_clk_i), .txd_i(line_txd_o), .drv_en_i(line_drv_en_o),
        .mode_485_i(cfg_i.mode_485), .line_o(node_line));

    initial
    begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    task automatic print_verdict();
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic check_rng(input string what, input int lo, input int hi, input int got);
        cmp_count++;
        if (got < lo || got > hi)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : check_rng

    task automatic set_cfg(input logic m, input logic x4, input logic [15:0] div, input logic pe);
        @(negedge ref_clk_i);
        cfg_i.mode_485 = m;
        cfg_i.clk_x4 = x4;
        cfg_i.divisor = div;
        cfg_i.parity_en = pe;
        repeat (4) @(negedge ref_clk_i);
    endtask : set_cfg

    task automatic push(input logic [7:0] b);
        while (tx_ready_o !== 1'b1)
            @(negedge ref_clk_i);
        tx_data_i = b;
        tx_valid_i = 1'b1;
        @(negedge ref_clk_i);
        tx_valid_i = 1'b0;
    endtask : push

    task automatic pop(input rad_rx_word_s exp);
        int k;
        k = 0;
        while (rx_valid_o !== 1'b1 && k < 3000)
        begin
            @(negedge ref_clk_i);
            k++;
        end
        check("rx valid", 16'h1, {15'h0, rx_valid_o});
        check("rx word", {6'h00, exp}, {6'h00, rx_word_o});
        rx_ready_i = 1'b1;
        @(negedge ref_clk_i);
        rx_ready_i = 1'b0;
    endtask : pop

    task automatic t_reset();
        check("txd idle", 16'h1, {15'h0, line_txd_o});
        check("drv idle", 16'h0, {15'h0, line_drv_en_o});
        check("rx en", 16'h1, {15'h0, line_rx_en_o});
        check("rx valid", 16'h0, {15'h0, rx_valid_o});
        ce_i = 1'b0;
        @(negedge ref_clk_i);
        check("ready off", 16'h0, {15'h0, tx_ready_o});
        ce_i = 1'b1;
    endtask : t_reset

    // Frame plus hold is 320 ticks for 8N1, ticks p cycles apart.
    task automatic t_hold(input logic [15:0] div, input logic x4, input int p);
        logic [11:0] f;
        int n;
        int bad;
        set_cfg(1'b1, x4, div, 1'b0);
        push(8'hA5);
        @(negedge ref_clk_i);
        n = 1;
        bad = 0;
        check("drv on", 16'h1, {15'h0, line_drv_en_o});
        fork
            node.recv(10, 16 * p, f);
            while (line_drv_en_o === 1'b1 && n < 5000)
            begin
                bad += (line_rx_en_o !== 1'b0);
                @(negedge ref_clk_i);
                n += (line_drv_en_o === 1'b1);
            end
        join
        check_rng("hold", 320 * p - 1, 321 * p + 2, n);
        check("rx off", 16'h0, bad[15:0]);
        check("rx back", 16'h1, {15'h0, line_rx_en_o});
        check("tx frame", {6'h0, 1'b1, 8'hA5, 1'b0}, {4'h0, f});
    endtask : t_hold

    task automatic t_recv();
        set_cfg(1'b1, 1'b1, 16'h0001, 1'b0);
        node.send({3'h0, 1'b1, 8'h3C, 1'b0}, 10, 16);
        pop({2'b00, 8'h3C});
        node.send({3'h0, 1'b0, 8'h5A, 1'b0}, 10, 16);
        pop({2'b10, 8'h5A});
        set_cfg(1'b1, 1'b1, 16'h0001, 1'b1);
        node.send({2'h0, 1'b1, 1'b0, 8'hC1, 1'b0}, 11, 16);
        pop({2'b01, 8'hC1});
        node.send({2'h0, 1'b1, 1'b0, 8'h81, 1'b0}, 11, 16);
        pop({2'b00, 8'h81});
    endtask : t_recv

    task automatic t_fifo_tx();
        int cnt;
        logic [11:0] f;
        set_cfg(1'b1, 1'b1, 16'h0001, 1'b0);
        cnt = 0;
        fork
            begin
                while (tx_ready_o === 1'b1 && cnt < 20)
                begin
                    tx_data_i = cnt[7:0];
                    tx_valid_i = 1'b1;
                    @(negedge ref_clk_i);
                    cnt++;
                end
                tx_valid_i = 1'b0;
            end
            node.recv(10, 16, f);
        join
        tx_valid_i = 1'b0;
        check_rng("tx depth", 16, 17, cnt);
        check("tx first", {6'h0, 1'b1, 8'h00, 1'b0}, {4'h0, f});
        for (int i = 1; i < cnt; i++)
        begin
            node.recv(10, 16, f);
            check("tx order", {6'h0, 1'b1, i[7:0], 1'b0}, {4'h0, f});
        end
        while (line_drv_en_o === 1'b1)
            @(negedge ref_clk_i);
    endtask : t_fifo_tx

    task automatic t_duplex();
        logic [11:0] f;
        set_cfg(1'b0, 1'b1, 16'h0001, 1'b0);
        check("drv 4w", 16'h1, {15'h0, line_drv_en_o});
        fork
            node.recv(10, 16, f);
            node.send({3'h0, 1'b1, 8'h69, 1'b0}, 10, 16);
            push(8'h96);
        join
        check("tx 4w", {6'h0, 1'b1, 8'h96, 1'b0}, {4'h0, f});
        pop({2'b00, 8'h69});
        repeat (200) @(negedge ref_clk_i);
        check("drv kept", 16'h1, {15'h0, line_drv_en_o});
        check("rx en 4w", 16'h1, {15'h0, line_rx_en_o});
    endtask : t_duplex

    task automatic t_rx_over();
        int ov;
        logic busy;
        ov = 0;
        busy = 1'b1;
        fork
            begin
                for (int i = 0; i < 18; i++)
                    node.send({3'h0, 1'b1, i[7:0], 1'b0}, 10, 16);
                busy = 1'b0;
            end
            while (busy)
            begin
                @(negedge ref_clk_i);
                ov += (rx_overrun_o === 1'b1);
            end
        join
        check_rng("overrun", 1, 2, ov);
        for (int i = 0; i < 16; i++)
            pop({2'b00, i[7:0]});
    endtask : t_rx_over

    initial
    begin
        repeat (60000) @(posedge ref_clk_i);
        n_errors++;
        print_verdict();
    end

    initial
    begin
        rst_i = 1'b1;
        // The host enables the port, dropping it for one cycle only in t_reset, as its interrupt gate bit is held low.
        ce_i = 1'b1;
        cfg_i = '0;
        cfg_i.mode_485 = 1'b1;
        cfg_i.clk_x4 = 1'b1;
        cfg_i.word_len = 2'h3;
        cfg_i.parity_even = 1'b1;
        cfg_i.stop_sel = STOP_SEL_1;
        cfg_i.divisor = 16'h0001;
        tx_data_i = 8'h00;
        tx_valid_i = 1'b0;
        rx_ready_i = 1'b0;
        repeat (2) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        rst_i = 1'b0;
        t_reset();
        t_hold(16'h0001, 1'b1, 1);
        t_hold(16'h0002, 1'b1, 2);
        t_hold(16'h0001, 1'b0, 4);
        t_recv();
        t_fifo_tx();
        t_duplex();
        t_rx_over();
        print_verdict();
    end
endmodule : tb
`default_nettype wire
